// ---- i2c_target_recovery_framing_tb.sv ----
`timescale 1ns/1ps
`include "itr_defines.svh"
module i2c_target_recovery_framing_tb;
	typedef struct
	{
		logic [7:0] dac;
		logic [7:0] bits;
		logic       chk;
		logic       bsy;
	} itr_exp_t;
	localparam logic [7:0] AW = {`ITR_ADDR_DEF, 1'b0};
	localparam logic [7:0] AR = {`ITR_ADDR_DEF, 1'b1};
	logic       clk_in, sys_rst_in, scl, sda_low, sda_oe, sda_o;
	logic       busy, ack, clash, r;
	logic [7:0] dac, fbits, lfsr, rd, val, prev;
	int         fail_count, n_tests;
	itr_exp_t   q[$];
	itr_exp_t   e;
	event       done;
	wire        sda = ~(sda_low | (sda_oe & ~sda_o));
	itr_target dut(.clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.dac_value_out(dac), .frame_bits_out(fbits), .busy_out(busy));
	itr_master m(.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda));
	function automatic logic [7:0] next_rand(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input string w, input logic [7:0] x, y);
		n_tests++;
		if (y !== x)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", w, x, y);
		end
	endtask
	task automatic summarize();
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] d);
		m.wbyte(d, ack, clash);
		check("ack", 8'h01, {7'h00, ack});
		check("release", 8'h00, {7'h00, clash});
	endtask
	task automatic frame_w(input logic [7:0] d);
		m.start_c();
		wr(AW);
		wr(8'h00);
		wr(d);
	endtask
	task automatic note(input logic [7:0] d, b, input logic c, s);
		q.push_back('{d, b, c, s});
		->done;
	endtask
	task automatic fin(input logic [7:0] d, b, input logic c);
		m.stop_c();
		repeat (20) @(negedge clk_in);
		note(d, b, c, 1'b0);
	endtask
	// ==========
	// Result watcher
	initial
		forever
		begin
			@(done);
			e = q.pop_front();
			check("value", e.dac, dac);
			if (e.chk)
				check("frame bits", e.bits, fbits);
			check("busy", {7'h00, e.bsy}, {7'h00, busy});
		end
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial
	begin
		#900000;
		fail_count++;
		summarize();
	end
	// ==========
	// Main sequence
	initial
	begin
		sys_rst_in = 1'b1;
		fail_count = 0;
		n_tests = 0;
		lfsr = 8'h47;
		repeat (5) @(negedge clk_in);
		sys_rst_in = 1'b0;
		repeat (10) @(negedge clk_in);
		note(`ITR_DAC_RST, `ITR_FBITS_RST, 1'b1, 1'b0);
		repeat (3)
		begin
			lfsr = next_rand(lfsr);
			frame_w(lfsr);
			fin(lfsr, 8'h1D, 1'b1);
		end
		m.start_c();
		wr(AW);
		wr(8'h00);
		for (int i = 0; i < 4; i++)
		begin
			prev = lfsr;
			lfsr = next_rand(lfsr);
			wr(lfsr);
			repeat (20) @(negedge clk_in);
			if (i > 0)
				note(prev, 8'h00, 1'b0, 1'b1);
		end
		val = lfsr;
		fin(val, 8'h38, 1'b1);
		frame_w(~val);
		m.start_c();
		fin(val, 8'h1E, 1'b1);
		m.start_c();
		wr(AW);
		wr(8'h00);
		m.start_c();
		wr(AR);
		m.rbyte(1'b1, rd);
		check("read", val, rd);
		fin(val, 8'h27, 1'b1);
		m.start_c();
		wr(AW);
		wr(8'h00);
		repeat (4) m.bit_io(1'b0, r);
		lfsr = next_rand(lfsr);
		val = lfsr;
		frame_w(val);
		fin(val, 8'h34, 1'b1);
		m.start_c();
		wr(AW);
		wr(8'h00);
		m.start_c();
		wr(AR);
		repeat (3) m.bit_io(1'b1, r);
		m.start_c();
		repeat (9) m.bit_io(1'b1, r);
		m.start_c();
		fin(val, 8'h00, 1'b0);
		m.scl_out = 1'b0;
		#80;
		m.wbyte(AW, ack, clash);
		check("idle ack", 8'h00, {7'h00, ack});
		m.wbyte(~val, ack, clash);
		fin(val, 8'h00, 1'b0);
		summarize();
	end
endmodule

// ---- itr_defines.svh ----
`ifndef ITR_DEFINES_SVH
`define ITR_DEFINES_SVH

// Bit counter value of the ninth (acknowledge) bit slot.
`define ITR_ACK_SLOT   4'h8
// Bit counter value at the start of a byte.
`define ITR_BIT_FIRST  4'h0
// Bus bit times charged for the start condition that opens a frame.
`define ITR_COND_BITS  8'h01
// Frame bit count after reset.
`define ITR_FBITS_RST  8'h00
// Stored output value after reset.
`define ITR_DAC_RST    8'h20
// Default target address; the value is arbitrary.
`define ITR_ADDR_DEF   7'h3A
// Read/write flag position in the address byte.
`define ITR_RW_BIT     0

`endif

// ---- itr_master.sv ----
`timescale 1ns/1ps
// ==========
// Bus master model
module itr_master
(
	// Bus pins; SDA is pulled low or released.
	output logic            scl_out,
	output logic            sda_low_out,
	input  wire logic       sda_in
);
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// SDA only moves while SCL is low, so no false start or stop.
	task automatic bit_io(input logic b, output logic r);
		sda_low_out = ~b;
		#80;
		scl_out = 1'b1;
		#160;
		r = sda_in;
		scl_out = 1'b0;
		#80;
	endtask
	task automatic start_c();
		sda_low_out = 1'b0;
		#80;
		scl_out = 1'b1;
		#160;
		sda_low_out = 1'b1;
		#160;
		scl_out = 1'b0;
		#80;
	endtask
	task automatic stop_c();
		sda_low_out = 1'b1;
		#80;
		scl_out = 1'b1;
		#160;
		sda_low_out = 1'b0;
		#160;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack,
		output logic clash);
		logic r;
		clash = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], r);
			clash = clash | (r != d[i]);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask
endmodule

// ---- itr_pkg.sv ----
package itr_pkg;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_WDATA,
		ST_RDATA
	} itr_state_t;

	typedef struct packed
	{
		logic scl;
		logic sda;
	} itr_pins_t;

endpackage

// ---- itr_target.sv ----
`timescale 1ns/1ps
`include "itr_defines.svh"
// How it works
// - Write 29, continuous 20+9N, read 39 bits.
// - Continuous write commits each data byte at the next byte's acknowledge or at stop.
// - Recovery resets interface only, keeps output value.
// - Start aborts any partial transfer and resets.
// - Release SDA at bit boundary after driving low.
// - Master not-acknowledge ends read transmit mode.
// - Commit on stop; repeated start discards pending write.
// - After stop stay idle until next start.
module itr_target
	import itr_pkg::*;
(
	// System clock and reset.
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	// Bus pins; SCL also clocks the link-side bit capture.
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	// Stored output value and frame statistics.
	output logic [7:0]      dac_value_out,
	output logic [7:0]      frame_bits_out,
	output logic            busy_out
);

	// =========================================================
	// Link domain: SDA captured on each rising SCL edge.
	// =========================================================
	logic link_bit_q;
	logic link_tgl_q;

	always_ff @(posedge scl_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			link_bit_q <= 1'b0;
			link_tgl_q <= 1'b0;
		end
		else
		begin
			link_bit_q <= sda_in;
			link_tgl_q <= ~link_tgl_q;
		end
	end

	// =========================================================
	// Synchronisers: a change counts once stages two and three agree.
	// =========================================================
	itr_pins_t pin_sh0_q;
	itr_pins_t pin_sh1_q;
	itr_pins_t pin_sh2_q;
	itr_pins_t pins_q;
	itr_pins_t pins_prev_q;
	logic [2:0] tgl_sh_q;
	logic       tgl_s_q;
	logic       tgl_prev_q;

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			pin_sh0_q   <= '1;
			pin_sh1_q   <= '1;
			pin_sh2_q   <= '1;
			pins_q      <= '1;
			pins_prev_q <= '1;
			tgl_sh_q    <= '0;
			tgl_s_q     <= 1'b0;
			tgl_prev_q  <= 1'b0;
		end
		else
		begin
			pin_sh0_q   <= '{scl: scl_in, sda: sda_in};
			pin_sh1_q   <= pin_sh0_q;
			pin_sh2_q   <= pin_sh1_q;
			if (pin_sh1_q.scl == pin_sh2_q.scl)
				pins_q.scl <= pin_sh2_q.scl;
			if (pin_sh1_q.sda == pin_sh2_q.sda)
				pins_q.sda <= pin_sh2_q.sda;
			pins_prev_q <= pins_q;
			tgl_sh_q    <= {tgl_sh_q[1:0], link_tgl_q};
			if (tgl_sh_q[1] == tgl_sh_q[2])
				tgl_s_q <= tgl_sh_q[2];
			tgl_prev_q  <= tgl_s_q;
		end
	end

	// Bus events in the system domain.
	logic start_ev;
	logic stop_ev;
	logic bit_ev;
	logic scl_fall;

	assign start_ev = pins_q.scl && pins_prev_q.scl &&
	                  pins_prev_q.sda && !pins_q.sda;
	assign stop_ev  = pins_q.scl && pins_prev_q.scl &&
	                  !pins_prev_q.sda && pins_q.sda;
	assign bit_ev   = (tgl_s_q != tgl_prev_q) && !start_ev && !stop_ev;
	assign scl_fall = pins_prev_q.scl && !pins_q.scl;

	// =========================================================
	// Interface state machine.
	// =========================================================
	itr_state_t state_q;
	logic [3:0] bitcnt_q;
	logic [7:0] rx_sh_q;
	logic [7:0] tx_sh_q;
	logic       ack_pend_q;
	logic       pend_v_q;
	logic [7:0] pend_q;
	logic [7:0] dac_q;
	logic       commit;
	logic       addr_hit;

	// Link bit is stable while SCL is high, so it is read on the event.
	assign addr_hit = (rx_sh_q[7:1] == `ITR_ADDR_DEF);
	assign commit   = pend_v_q && (stop_ev || (bit_ev &&
	                  state_q == ST_WDATA && bitcnt_q == `ITR_ACK_SLOT));

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			state_q    <= ST_IDLE;
			bitcnt_q   <= `ITR_BIT_FIRST;
			rx_sh_q    <= '0;
			tx_sh_q    <= '0;
			ack_pend_q <= 1'b0;
			pend_v_q   <= 1'b0;
			pend_q     <= '0;
		end
		else if (start_ev)
		begin
			state_q    <= ST_ADDR;
			bitcnt_q   <= `ITR_BIT_FIRST;
			ack_pend_q <= 1'b0;
			pend_v_q   <= 1'b0;
		end
		else if (stop_ev)
		begin
			state_q    <= ST_IDLE;
			bitcnt_q   <= `ITR_BIT_FIRST;
			ack_pend_q <= 1'b0;
			pend_v_q   <= 1'b0;
		end
		else if (bit_ev && state_q != ST_IDLE)
		begin
			if (bitcnt_q != `ITR_ACK_SLOT)
			begin
				rx_sh_q  <= {rx_sh_q[6:0], link_bit_q};
				tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
				bitcnt_q <= bitcnt_q + 4'h1;
				if (bitcnt_q == `ITR_ACK_SLOT - 4'h1)
					ack_pend_q <= (state_q != ST_RDATA) &&
					              ((state_q != ST_ADDR) ||
					              (rx_sh_q[6:0] == `ITR_ADDR_DEF));
			end
			else
			begin
				bitcnt_q   <= `ITR_BIT_FIRST;
				ack_pend_q <= 1'b0;
				unique case (state_q)
					ST_ADDR:
						if (!addr_hit)
							state_q <= ST_IDLE;
						else if (rx_sh_q[`ITR_RW_BIT])
						begin
							state_q <= ST_RDATA;
							tx_sh_q <= dac_q;
						end
						else
							state_q <= ST_CMD;
					ST_CMD:
						state_q <= ST_WDATA;
					ST_WDATA:
					begin
						pend_q   <= rx_sh_q;
						pend_v_q <= 1'b1;
					end
					ST_RDATA:
						if (link_bit_q)
							state_q <= ST_IDLE;
						else
							tx_sh_q <= dac_q;
					ST_IDLE:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// =========================================================
	// Stored value: touched only by a committed write.
	// =========================================================
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			dac_q <= `ITR_DAC_RST;
		else if (commit)
			dac_q <= pend_q;
	end

	// =========================================================
	// SDA driver: changes only while SCL is low.
	// =========================================================
	logic sda_low_q;

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			sda_low_q <= 1'b0;
		else if (start_ev || stop_ev)
			sda_low_q <= 1'b0;
		else if (scl_fall)
			sda_low_q <= (bitcnt_q == `ITR_ACK_SLOT) ? ack_pend_q :
			             (state_q == ST_RDATA && !tx_sh_q[7]);
	end

	// =========================================================
	// Frame length in bus bit times, start and stop included.
	// =========================================================
	logic [7:0] fbits_q;
	logic [7:0] fbits_last_q;
	logic       in_frame_q;

	// The SCL rise ahead of a repeated start or a stop is that condition's
	// own bit time, so neither adds to it; stops on an idle bus are ignored.
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			fbits_q      <= `ITR_FBITS_RST;
			fbits_last_q <= `ITR_FBITS_RST;
			in_frame_q   <= 1'b0;
		end
		else if (start_ev)
		begin
			fbits_q    <= in_frame_q ? fbits_q : `ITR_COND_BITS;
			in_frame_q <= 1'b1;
		end
		else if (stop_ev)
		begin
			fbits_last_q <= in_frame_q ? fbits_q : fbits_last_q;
			in_frame_q   <= 1'b0;
		end
		else if (bit_ev && in_frame_q)
			fbits_q <= fbits_q + 8'h01;
	end

	assign sda_out        = 1'b0;
	assign sda_oe_out     = sda_low_q;
	assign dac_value_out  = dac_q;
	assign frame_bits_out = fbits_last_q;
	assign busy_out       = (state_q != ST_IDLE);

	// =========================================================
	// Checks.
	// =========================================================
	a_start_resets_fsm: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) start_ev |=> state_q == ST_ADDR &&
		bitcnt_q == `ITR_BIT_FIRST && !sda_oe_out)
		else $error("start did not reset interface");
	a_start_drops_write: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) start_ev |=> !pend_v_q ##1 $stable(dac_q))
		else $error("repeated start kept pending write");
	a_recovery_keeps_dac: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) !commit |=> $stable(dac_value_out))
		else $error("output value changed without commit");
	a_stop_goes_idle: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		stop_ev |=> !busy_out ##1 (!busy_out || $past(start_ev)))
		else $error("not idle after stop");
	a_nack_ends_read: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) bit_ev && state_q == ST_RDATA &&
		bitcnt_q == `ITR_ACK_SLOT && link_bit_q |=> state_q == ST_IDLE)
		else $error("read continued after not-acknowledge");
	a_ack_driven_low: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) scl_fall && !start_ev && !stop_ev &&
		bitcnt_q == `ITR_ACK_SLOT && ack_pend_q |=> sda_oe_out)
		else $error("acknowledge not driven");
	a_sda_released: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) scl_fall && state_q != ST_RDATA &&
		bitcnt_q != `ITR_ACK_SLOT |=> !sda_oe_out)
		else $error("SDA held past bit boundary");
	a_stop_commits: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) stop_ev && pend_v_q |=>
		dac_value_out == $past(pend_q))
		else $error("acknowledged write not committed");
	a_frame_count: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) stop_ev && in_frame_q |=>
		frame_bits_out == $past(fbits_q))
		else $error("frame bit count wrong");

endmodule
